// ### common/stco_regs.vh
/*
 * Constants for the start-up timer and clock-output block: register
 * field layout, reset values, divider encodings and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef STCO_REGS_VH
`define STCO_REGS_VH

// Clock output control register layout
`define STCO_CFG_WIDTH 8
`define STCO_SEL_MSB 2
`define STCO_SEL_LSB 0
`define STCO_SEL_RESET 3'h4

// Output divider select codes
`define STCO_SEL_OFF 3'h0
`define STCO_SEL_DIV1 3'h1
`define STCO_SEL_DIV2 3'h2
`define STCO_SEL_DIV3 3'h3
`define STCO_SEL_DIV4 3'h4
`define STCO_SEL_DIV8 3'h5

// Status register layout
`define STCO_STAT_RDY_BIT 0

// Clock rates in MHz
`define STCO_SYS_CLK_MHZ 100
`define STCO_MAIN_CLK_MHZ 25

// Start-up delay in microseconds and in main oscillator cycles
`define STCO_STARTUP_TIME_US 300
`define STCO_STARTUP_CYCLES 13'h1D4C

// Pulse-free gap on a ratio change, in half main periods (2 main periods)
`define STCO_GAP_HALF_TICKS 4'h4

`endif

// ### logic/stco_div.v
/*
 * Divider core for the clock output: produces a 50 % duty level whose
 * half period is a whole number of half main-clock periods.
 * Assumes a one-cycle half-period enable and a run level from the top.
 */
`timescale 1ns/1ns

module stco_div
(
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Control
	input wire half_tick,
	input wire run,
	input wire [3:0] half_len,
	// Result
	output reg level,
	output reg fall
);

reg [3:0] phase_cnt;

// ************************************************************
// Phase counter and output level
// ************************************************************

// Starts low, first rise after one full half period
always @(posedge sys_clk)
begin
	if (!reset_n || !run)
	begin
		phase_cnt <= 4'h0;
		level <= 1'b0;
		fall <= 1'b0;
	end
	else if (half_tick)
	begin
		if (phase_cnt == half_len - 4'h1)
		begin
			phase_cnt <= 4'h0;
			level <= ~level;
			fall <= level; // Pulse as high phase ends
		end
		else
		begin
			phase_cnt <= phase_cnt + 4'h1;
			fall <= 1'b0;
		end
	end
	else
	begin
		fall <= 1'b0;
	end
end

endmodule // stco_div

// ### logic/stco_top.v
/*
 * Oscillator start-up timer and programmable clock output.
 * sys_clk is the 100 MHz core clock; the 25 MHz main clock and its
 * half periods are one-cycle enables derived from it. power_down and
 * the register strobes come from logic on the same clock.
 */
`timescale 1ns/1ns
`include "stco_regs.vh"

module stco_top
#(
	parameter [12:0] STARTUP_CYCLES = `STCO_STARTUP_CYCLES
)
(
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Power control
	input wire power_down,
	// Clock output control register access
	input wire cfg_wr,
	input wire [7:0] cfg_wr_data,
	output reg [7:0] cfg_rd_data,
	// Status
	output reg [7:0] status_rd_data,
	output reg clock_ready_flag,
	// Clock output pin
	output reg clock_output_pin
);

// ************************************************************
// Constants and functions
// ************************************************************

// Last count of the core cycles in one main oscillator period
localparam integer MAIN_DIV_LAST_I = (`STCO_SYS_CLK_MHZ / `STCO_MAIN_CLK_MHZ) - 1;
localparam [1:0] MAIN_DIV_LAST = MAIN_DIV_LAST_I[1:0];

// Clock output sequencer states
localparam [1:0] ST_WAIT = 2'b00;
localparam [1:0] ST_OFF = 2'b01;
localparam [1:0] ST_GAP = 2'b10;
localparam [1:0] ST_RUN = 2'b11;

// Half period of the output in half main periods
function [3:0] sel_half_len;
	input [2:0] sel;
	begin
		case (sel)
			`STCO_SEL_DIV1: sel_half_len = 4'h1;
			`STCO_SEL_DIV2: sel_half_len = 4'h2;
			`STCO_SEL_DIV3: sel_half_len = 4'h3;
			`STCO_SEL_DIV4: sel_half_len = 4'h4;
			`STCO_SEL_DIV8: sel_half_len = 4'h8;
			default: sel_half_len = 4'h8; // Reserved codes run slowest
		endcase
	end
endfunction

// ************************************************************
// Declarations
// ************************************************************

reg [1:0] main_div_cnt;
reg half_tick;
reg main_tick;
reg [2:0] out_sel;
reg [12:0] timer_cnt;
reg timer_busy;
reg timer_expired;
reg power_down_q;
reg [1:0] state;
reg [2:0] active_sel;
reg [3:0] gap_cnt;
reg div_run;
wire div_level;
wire div_fall;
wire wake;
wire sel_changed;

// ************************************************************
// Main clock enables
// ************************************************************

// Half-period enable every two core cycles, main enable every four
always @(posedge sys_clk)
begin
	if (!reset_n)
	begin
		main_div_cnt <= 2'h0;
		half_tick <= 1'b0;
		main_tick <= 1'b0;
		power_down_q <= 1'b0;
	end
	else
	begin
		main_div_cnt <= main_div_cnt + 2'h1;
		half_tick <= main_div_cnt[0];
		main_tick <= (main_div_cnt == MAIN_DIV_LAST);
		power_down_q <= power_down; // Delayed level for wake detection
	end
end

// ************************************************************
// Clock output control register
// ************************************************************

// Only power-on reset restores the default select; upper read-back bits zero
always @(posedge sys_clk)
begin
	if (!reset_n)
	begin
		out_sel <= `STCO_SEL_RESET;
		cfg_rd_data <= 8'h00;
	end
	else
	begin
		cfg_rd_data <= {5'h00, out_sel};
		if (cfg_wr)
		begin
			out_sel <= cfg_wr_data[`STCO_SEL_MSB:`STCO_SEL_LSB];
		end
		// No soft or pin reset input reaches this register
	end
end

// ************************************************************
// Start-up delay timer
// ************************************************************

// Wake is the fall of the power-down level
assign wake = power_down_q && !power_down;

// Counts main cycles after power-on reset or wake
always @(posedge sys_clk)
begin
	if (!reset_n)
	begin
		timer_cnt <= 13'h0000;
		timer_busy <= 1'b1;
		timer_expired <= 1'b0;
	end
	else if (wake)
	begin
		timer_cnt <= 13'h0000;
		timer_busy <= 1'b1;
		timer_expired <= 1'b0;
	end
	else if (power_down)
	begin
		timer_cnt <= 13'h0000;
		timer_expired <= 1'b0;
	end
	else if (timer_busy && main_tick)
	begin
		if (timer_cnt == STARTUP_CYCLES - 13'h0001)
		begin
			timer_busy <= 1'b0;
			timer_expired <= 1'b1;
		end
		else
		begin
			timer_cnt <= timer_cnt + 13'h0001;
			timer_expired <= 1'b0;
		end
	end
	else
	begin
		timer_expired <= 1'b0;
	end
end

// Ready flag: cleared on restart, set on expiry
always @(posedge sys_clk)
begin
	if (!reset_n)
	begin
		clock_ready_flag <= 1'b0;
	end
	else if (timer_expired)
	begin
		clock_ready_flag <= 1'b1;
	end
	else if (wake || power_down)
	begin
		clock_ready_flag <= 1'b0;
	end
end

// Status byte seen by software polling for readiness
always @(posedge sys_clk)
begin
	if (!reset_n)
	begin
		status_rd_data <= 8'h00;
	end
	else
	begin
		status_rd_data <= 8'h00;
		status_rd_data[`STCO_STAT_RDY_BIT] <= clock_ready_flag;
	end
end

// ************************************************************
// Clock output sequencer
// ************************************************************

// Pending change of select while running
assign sel_changed = (out_sel != active_sel);

// Waits for first expiry, then stops only at a falling edge
always @(posedge sys_clk)
begin
	if (!reset_n)
	begin
		state <= ST_WAIT;
		active_sel <= `STCO_SEL_OFF;
		gap_cnt <= 4'h0;
		div_run <= 1'b0;
	end
	else
	begin
		case (state)
			ST_WAIT:
			begin
				div_run <= 1'b0;
				gap_cnt <= 4'h0;
				if (timer_expired)
				begin
					state <= (out_sel == `STCO_SEL_OFF) ? ST_OFF : ST_GAP;
				end
			end
			ST_OFF:
			begin
				div_run <= 1'b0;
				gap_cnt <= 4'h0;
				active_sel <= `STCO_SEL_OFF;
				if (out_sel != `STCO_SEL_OFF)
				begin
					state <= ST_GAP;
				end
			end
			ST_GAP:
			begin
				div_run <= 1'b0;
				if (half_tick)
				begin
					if (gap_cnt == `STCO_GAP_HALF_TICKS - 4'h1)
					begin
						gap_cnt <= 4'h0;
						if (out_sel == `STCO_SEL_OFF)
						begin
							state <= ST_OFF;
						end
						else
						begin
							active_sel <= out_sel;
							div_run <= 1'b1;
							state <= ST_RUN;
						end
					end
					else
					begin
						gap_cnt <= gap_cnt + 4'h1;
					end
				end
			end
			ST_RUN:
			begin
				// Cut only as a high phase ends, never inside one
				if (sel_changed && div_fall)
				begin
					div_run <= 1'b0;
					gap_cnt <= 4'h0;
					state <= ST_GAP;
				end
			end
			default:
			begin
				state <= ST_WAIT;
				div_run <= 1'b0;
				gap_cnt <= 4'h0;
			end
		endcase
	end
end

// ************************************************************
// Divider and pin
// ************************************************************

// New divider starts low for a full half period
stco_div u_div
(
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.half_tick(half_tick),
	.run(div_run),
	.half_len(sel_half_len(active_sel)),
	.level(div_level),
	.fall(div_fall)
);

// Pin follows the divider; power-down does not stop it
always @(posedge sys_clk)
begin
	if (!reset_n)
	begin
		clock_output_pin <= 1'b0;
	end
	else
	begin
		clock_output_pin <= div_level && (state == ST_RUN);
	end
end

endmodule // stco_top

// ### tb/stco_top_properties.sv
/* Port checker for the start-up timer and clock output.
   Assumes a bind onto stco_top. */
`timescale 1ns/1ns
module stco_chk
#(
	parameter [12:0] STARTUP_CYCLES = 13'h1D4C
)
(
	// Clock and reset
	input wire sys_clk,
	input wire reset_n,
	// Watched ports
	input wire power_down,
	input wire cfg_wr,
	input wire [7:0] cfg_wr_data,
	input wire [7:0] cfg_rd_data,
	input wire [7:0] status_rd_data,
	input wire clock_ready_flag,
	input wire clock_output_pin
);
	reg [15:0] t_cnt;
	reg [7:0] h_cnt;
	reg [7:0] o_cnt;
	reg seen;
	// Timer age, high run, off span, first expiry seen
	always @(posedge sys_clk)
	begin
		t_cnt <= (reset_n && !power_down) ? t_cnt + 16'h0001 : 16'h0000;
		h_cnt <= clock_output_pin ? h_cnt + 8'h01 : 8'h00;
		o_cnt <= (!reset_n || cfg_rd_data[2:0] != 3'h0) ? 8'h00 : o_cnt + {7'h00, o_cnt != 8'hFF};
		seen <= reset_n && (seen || clock_ready_flag);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	//****
	// Assertions
	//****
	pin_held_low_a: assert property (!seen && !clock_ready_flag |-> !clock_output_pin)
		else $error("clock pin active before ready");
	timer_length_a: assert property ($rose(clock_ready_flag) |->
		t_cnt >= 4 * STARTUP_CYCLES - 4 && t_cnt <= 4 * STARTUP_CYCLES + 8)
		else $error("ready at wrong time");
	status_copy_a: assert property (status_rd_data == {7'h00, $past(clock_ready_flag)})
		else $error("status byte wrong");
	ready_hold_a: assert property (clock_ready_flag && !power_down |=> clock_ready_flag)
		else $error("ready dropped");
	ready_clear_a: assert property (power_down |=> !clock_ready_flag)
		else $error("ready kept in power down");
	upper_zero_a: assert property (cfg_rd_data[7:3] == 5'h00)
		else $error("upper bits not zero");
	write_back_a: assert property (cfg_wr |=> ##1 cfg_rd_data == ($past(cfg_wr_data, 2) & 8'h07))
		else $error("select readback wrong");
	high_width_a: assert property ($fell(clock_output_pin) |-> h_cnt inside {2, 4, 6, 8, 16})
		else $error("high phase width wrong");
	off_low_a: assert property (o_cnt >= 8'h14 |-> !clock_output_pin)
		else $error("pin high while off");
	cover property ($rose(clock_ready_flag));
	cover property ($fell(clock_output_pin) && h_cnt == 8'h02);
	cover property (power_down && clock_output_pin);
endmodule // stco_chk

bind stco_top stco_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.sys_clk(sys_clk),
	.reset_n(reset_n), .power_down(power_down), .cfg_wr(cfg_wr), .cfg_wr_data(cfg_wr_data),
	.cfg_rd_data(cfg_rd_data), .status_rd_data(status_rd_data),
	.clock_ready_flag(clock_ready_flag), .clock_output_pin(clock_output_pin));

// ### tb/stco_clk_sink.sv
/* Device clocked from the output pin: measures each phase.
   Assumes the pin is sampled on the core clock. */
`timescale 1ns/1ns
module stco_clk_sink
(
	// Clock
	input wire sys_clk,
	// Pin and phase report
	input wire clk_in,
	output reg meas_valid,
	output reg meas_hi,
	output reg [7:0] meas_len
);
	reg prev = 1'b0;
	reg [7:0] run = 8'h00;
	// Report the length of each finished phase
	always @(posedge sys_clk)
	begin
		meas_valid <= clk_in !== prev;
		meas_hi <= prev;
		meas_len <= run;
		run <= (clk_in !== prev) ? 8'h01 : run + 8'h01;
		prev <= clk_in;
	end
endmodule // stco_clk_sink

// ### tb/tb_startup_timer_clock_output.sv
/* Self-checking bench for stco_top.
   Assumes stco_chk is bound and stco_clk_sink watches the pin. */
`timescale 1ns/1ns
module tb_startup_timer_clock_output;
	localparam [12:0] SC = 13'h0014;
	reg sys_clk = 1'b0;
	reg reset_n = 1'b0;
	reg power_down = 1'b0;
	reg cfg_wr = 1'b0;
	reg [7:0] cfg_wr_data = 8'h00;
	wire [7:0] cfg_rd_data;
	wire [7:0] status_rd_data;
	wire clock_ready_flag;
	wire clock_output_pin;
	wire meas_valid;
	wire meas_hi;
	wire [7:0] meas_len;
	reg [8:0] exp_q[$];
	reg [31:0] lfsr = 32'h00015F69;
	reg [7:0] n;
	reg [2:0] s;
	integer n_mismatch = 0;
	integer n_compared = 0;
	integer k;
	always #5 sys_clk = ~sys_clk;
	stco_top #(.STARTUP_CYCLES(SC)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.power_down(power_down), .cfg_wr(cfg_wr), .cfg_wr_data(cfg_wr_data),
		.cfg_rd_data(cfg_rd_data), .status_rd_data(status_rd_data),
		.clock_ready_flag(clock_ready_flag), .clock_output_pin(clock_output_pin));
	stco_clk_sink u_sink (.sys_clk(sys_clk), .clk_in(clock_output_pin),
		.meas_valid(meas_valid), .meas_hi(meas_hi), .meas_len(meas_len));
	//****
	// Tasks
	//****
	task finish_test;
	begin
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task chk(input [8*6-1:0] nm, input [8:0] e, input [8:0] g);
	begin
		n_compared = n_compared + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task step(input integer c);
	begin
		repeat (c) @(posedge sys_clk);
		#1;
	end
	endtask
	task tmo(input integer c);
	begin
		if (c >= 400)
		begin
			chk("wait", 9'h000, 9'h1FF);
			finish_test;
		end
	end
	endtask
	// Bounded wait for ready (w 0) or a pin level (w 1)
	task wait_sig(input integer w, input v);
		integer c;
	begin
		c = 0;
		while ((w ? clock_output_pin : clock_ready_flag) !== v && c < 400)
		begin
			step(1);
			c = c + 1;
		end
		tmo(c);
	end
	endtask
	task drain;
		integer c;
	begin
		for (c = 0; c < 400 && exp_q.size() > 0; c = c + 1)
			step(1);
		tmo(c);
	end
	endtask
	function [31:0] lfsr_next(input [31:0] v);
		lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task wr(input [2:0] sel);
	begin
		lfsr = lfsr_next(lfsr);
		cfg_wr = 1'b1;
		cfg_wr_data = {lfsr[7:3], sel};
		step(1);
		cfg_wr = 1'b0;
		step(2);
	end
	endtask
	// Pop the oldest note when a phase of the same kind ends
	always @(posedge sys_clk)
		if (meas_valid && exp_q.size() > 0 && exp_q[0][8] === meas_hi)
			chk("phase", exp_q.pop_front(), {meas_hi, meas_len});
	//****
	// Sequence
	//****
	initial
	begin
		step(12);
		reset_n = 1'b1;
		step(2);
		chk("rd", 9'h004, {1'b0, cfg_rd_data});
		chk("pin", 9'h000, {8'h00, clock_output_pin});
		wr(3'h2);
		chk("rd", 9'h002, {1'b0, cfg_rd_data});
		wr(3'h4);
		chk("rd", 9'h004, {1'b0, cfg_rd_data});
		wait_sig(0, 1'b1);
		step(1);
		chk("stat", 9'h001, {1'b0, status_rd_data});
		exp_q.push_back(9'h108);
		drain;
		for (k = 0; k < 6; k = k + 1)
		begin
			s = (k < 5) ? k[2:0] + 3'h1 : lfsr[10:8] % 3'h5 + 3'h1;
			n = (s == 3'h5) ? 8'h08 : {5'h00, s};
			wr((s == 3'h5) ? 3'h1 : 3'h5);
			step(40);
			wait_sig(1, 1'b0);
			wait_sig(1, 1'b1);
			wr(s);
			exp_q.push_back({1'b0, 8'h08 + 8'h02 * n});
			exp_q.push_back({1'b1, 8'h02 * n});
			drain;
			chk("rd", {6'h00, s}, {1'b0, cfg_rd_data});
		end
		power_down = 1'b1;
		step(2);
		chk("rdy", 9'h000, {8'h00, clock_ready_flag});
		exp_q.push_back({1'b1, 8'h02 * n});
		drain;
		power_down = 1'b0;
		step(2);
		chk("rdy", 9'h000, {8'h00, clock_ready_flag});
		wait_sig(0, 1'b1);
		exp_q.push_back({1'b1, 8'h02 * n});
		drain;
		wr(3'h0);
		step(30);
		s = 3'h0;
		for (k = 0; k < 40; k = k + 1)
		begin
			s[0] = s[0] | clock_output_pin;
			step(1);
		end
		chk("off", 9'h000, {6'h00, s});
		wr(3'h4);
		exp_q.push_back(9'h108);
		drain;
		finish_test;
	end
endmodule // tb_startup_timer_clock_output
